// >>> logic/usf_status_flow.sv
// usf_status_flow: line status, modem status, flow thresholds and
// flow-control characters of a uart register file
// assumes a host-port decoder on the same clock presents single-cycle
// read and write strobes, and that the receive fifo lives outside
//
// Overview of operation
// - line status bit 3 shows framing error of the head character
// - line status bit 2 shows parity error of the head character
// - bit 1 flags overrun; character arriving into a full fifo is dropped
// - bit 0 is set while the receive fifo holds any character
// - second_xon_char and first_xoff_char reachable only with line control 0xBF, feature bit 2 low
// - flow characters are cleared by power-on reset only
// - modem status selected when dlab, modem control 2, feature 2 all low
// - outside loopback bits 7..4 are inverted cd, ri, dsr, cts inputs
// - in loopback bits 7,6,5,4 follow modem control bits 3,2,0,1
// - bits 3,1,0 set when cd, dsr, cts change in either direction
// - bit 2 set only on ring input low to high
// - any change flag with modem interrupt enabled raises the interrupt
// - levels register selected when enhanced 4, modem control 2 set
// - fill at or above four times halt field halts remote sender
// - fill at or below four times resume field resumes remote sender
// - first_xoff_char holds the eight-bit stop character for software flow
// - modem control bit 4 loops transmit output back to receive input
`timescale 1ns/1ps
`default_nettype none
module usf_status_flow #(
  parameter int LEVEL_W = 7
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic POR,
  input wire usf_pkg::usf_ctl_t CTL,
  input wire usf_pkg::usf_req_t REQ,
  output logic [7:0] RDATA,
  input wire logic MODEM_IRQ_EN,
  output logic MODEM_IRQ,
  input wire logic [3:0] LINE_STATUS_HI,
  input wire logic RX_ARRIVE,
  input wire usf_pkg::usf_head_t RX_ARRIVE_INFO,
  input wire logic RX_FULL,
  output logic RX_PUSH,
  output usf_pkg::usf_head_t RX_PUSH_INFO,
  input wire logic RX_HEAD_LOAD,
  input wire usf_pkg::usf_head_t RX_HEAD_INFO,
  input wire logic [LEVEL_W-1:0] RX_LEVEL,
  input wire logic AUTO_RTS_EN,
  input wire logic AUTO_SW_EN,
  output logic RTS_N,
  output logic SEND_XOFF,
  output logic SEND_XON,
  output logic [7:0] FIRST_XOFF_CHAR_CHAR,
  output logic [7:0] SECOND_XON_CHAR_CHAR,
  input wire logic CD_N,
  input wire logic RI_N,
  input wire logic DSR_N,
  input wire logic CTS_N,
  input wire logic RX_PIN,
  input wire logic TX_OUT,
  output logic RX_CORE
);
  import usf_pkg::*;

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  logic [4:0] pin_raw;
  logic [4:0] pin_sync;

  // order: cts, dsr, ri, cd, serial receive
  assign pin_raw = {RX_PIN, CD_N, RI_N, DSR_N, CTS_N};

  usf_sync2 #(
    .WIDTH(5),
    .INIT(5'h1F)
  ) u_sync (
    .CLK(CLK),
    .RST(RST),
    .D(pin_raw),
    .Q(pin_sync)
  );

  // ***************************************************************
  // register selection
  // ***************************************************************
  logic loop_mode;
  logic enh_key;
  logic sfr_open;
  logic sel_second_xon_char;
  logic sel_first_xoff_char;
  logic sel_line;
  logic sel_modem;
  logic sel_levels;

  assign loop_mode = CTL.modem_control[MCR_LOOP];
  assign sfr_open = ~CTL.special_feature[SFR_SEL];
  assign enh_key = (CTL.line_control == LCR_ENHANCED_KEY);

  // character registers sit behind the enhanced key
  assign sel_second_xon_char = (REQ.addr == OFS_SECOND_XON_CHAR) && enh_key && sfr_open;
  assign sel_first_xoff_char = (REQ.addr == OFS_FIRST_XOFF_CHAR) && enh_key && sfr_open;
  assign sel_line = (REQ.addr == OFS_LINE_STATUS)
                    && ~CTL.line_control[LCR_DLAB];
  // modem status and level register share one offset
  assign sel_modem = (REQ.addr == OFS_MODEM_STATUS)
                     && ~CTL.line_control[LCR_DLAB]
                     && ~CTL.modem_control[MCR_SEL]
                     && sfr_open;
  assign sel_levels = (REQ.addr == OFS_LEVELS) && ~sel_first_xoff_char
                      && CTL.enhanced_feature[EFR_ENH]
                      && CTL.modem_control[MCR_SEL]
                      && sfr_open;

  // ***************************************************************
  // flow-control characters (power-on reset only)
  // ***************************************************************
  logic [7:0] second_xon_char_q;
  logic [7:0] first_xoff_char_q;

  // only the power-on reset clears these; RST leaves them alone
  always_ff @(posedge CLK or posedge POR) begin
    if (POR) begin
      second_xon_char_q <= RST_CHAR;
      first_xoff_char_q <= RST_CHAR;
    end else if (REQ.wr) begin
      if (sel_second_xon_char) begin
        second_xon_char_q <= REQ.wdata;
      end
      if (sel_first_xoff_char) begin
        first_xoff_char_q <= REQ.wdata;
      end
    end
  end

  // characters handed to the transmit side
  assign FIRST_XOFF_CHAR_CHAR = first_xoff_char_q;
  assign SECOND_XON_CHAR_CHAR = second_xon_char_q;

  // ***************************************************************
  // halt / resume levels register
  // ***************************************************************
  logic [7:0] levels_q;

  // written only where the shared offset selects it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      levels_q <= RST_LEVELS;
    end else if (REQ.wr && sel_levels) begin
      levels_q <= REQ.wdata;
    end
  end

  // ***************************************************************
  // receive fifo entry and line status
  // ***************************************************************
  logic frame_q;
  logic parity_q;
  logic overrun_q;
  logic line_rd;
  logic fifo_ready;

  assign line_rd = REQ.rd && sel_line;
  assign fifo_ready = (RX_LEVEL != '0);

  // a character arriving into a full fifo is not written
  assign RX_PUSH = RX_ARRIVE && ~RX_FULL;
  assign RX_PUSH_INFO = RX_ARRIVE_INFO;

  // head flags reload each time a new character reaches the head
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      frame_q <= 1'b0;
      parity_q <= 1'b0;
    end else if (RX_HEAD_LOAD) begin
      frame_q <= RX_HEAD_INFO.frame_err;
      parity_q <= RX_HEAD_INFO.parity_err;
    end else if (~fifo_ready) begin
      frame_q <= 1'b0;
      parity_q <= 1'b0;
    end
  end

  // overrun stays until line status is read; a new overrun wins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      overrun_q <= 1'b0;
    end else if (RX_ARRIVE && RX_FULL) begin
      overrun_q <= 1'b1;
    end else if (line_rd) begin
      overrun_q <= 1'b0;
    end
  end

  // ***************************************************************
  // modem input levels and change flags
  // ***************************************************************
  logic [3:0] pin_level;
  logic [3:0] loop_level;
  logic [3:0] mi_level;
  logic [3:0] mi_prev_q;
  logic [3:0] delta_q;
  logic [3:0] delta_set;
  logic modem_rd;

  // complement of the pins (order cts, dsr, ri, cd)
  assign pin_level = ~pin_sync[3:0];

  // loopback substitutes modem control bits
  assign loop_level[MI_CD] = CTL.modem_control[MCR_OP2];
  assign loop_level[MI_RI] = CTL.modem_control[MCR_SEL];
  assign loop_level[MI_DSR] = CTL.modem_control[MCR_DTR];
  assign loop_level[MI_CTS] = CTL.modem_control[MCR_RTS];

  assign mi_level = loop_mode ? loop_level : pin_level;
  assign modem_rd = REQ.rd && sel_modem;

  // any-edge detect for cd, dsr, cts; rising pin edge only for ring
  always_comb begin
    delta_set = mi_level ^ mi_prev_q;
    // ring pin low to high is status bit high to low
    delta_set[MI_RI] = mi_prev_q[MI_RI] & ~mi_level[MI_RI];
  end

  // previous levels for the edge detector
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mi_prev_q <= '0;
    end else begin
      mi_prev_q <= mi_level;
    end
  end

  // change flags: set wins over the read that clears them
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      delta_q <= '0;
    end else if (modem_rd) begin
      delta_q <= delta_set;
    end else begin
      delta_q <= delta_q | delta_set;
    end
  end

  // interrupt while any change flag is set and enabled
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      MODEM_IRQ <= 1'b0;
    end else if (modem_rd) begin
      MODEM_IRQ <= MODEM_IRQ_EN && (delta_set != '0);
    end else begin
      MODEM_IRQ <= MODEM_IRQ_EN && ((delta_q | delta_set) != '0);
    end
  end

  // ***************************************************************
  // automatic flow control thresholds
  // ***************************************************************
  logic [LEVEL_W-1:0] halt_lvl;
  logic [LEVEL_W-1:0] resume_lvl;
  logic at_halt;
  logic at_resume;
  logic halted_q;
  logic go_halt;
  logic go_resume;

  // fields scaled by four
  assign halt_lvl = LEVEL_W'({levels_q[LV_HALT_LO +: LV_FIELD_W], 2'b00});
  assign resume_lvl = LEVEL_W'({levels_q[LV_RESUME_LO +: LV_FIELD_W], 2'b00});
  assign at_halt = (RX_LEVEL >= halt_lvl);
  assign at_resume = (RX_LEVEL <= resume_lvl);
  // software keeps resume below halt; halt is checked first
  assign go_halt = ~halted_q && at_halt;
  assign go_resume = halted_q && at_resume && ~at_halt;

  // hysteresis between the two thresholds
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      halted_q <= 1'b0;
    end else if (~AUTO_RTS_EN && ~AUTO_SW_EN) begin
      halted_q <= 1'b0;
    end else if (go_halt) begin
      halted_q <= 1'b1;
    end else if (go_resume) begin
      halted_q <= 1'b0;
    end
  end

  // request-to-send pin and xon/xoff send requests
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RTS_N <= 1'b1;
      SEND_XOFF <= 1'b0;
      SEND_XON <= 1'b0;
    end else begin
      if (AUTO_RTS_EN) begin
        RTS_N <= go_halt || (halted_q && ~go_resume);
      end else begin
        RTS_N <= ~CTL.modem_control[MCR_RTS];
      end
      SEND_XOFF <= AUTO_SW_EN && go_halt;
      SEND_XON <= AUTO_SW_EN && go_resume;
    end
  end

  // ***************************************************************
  // internal loopback of the serial data
  // ***************************************************************
  // receive path takes transmit output while looped
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RX_CORE <= 1'b1;
    end else begin
      RX_CORE <= loop_mode ? TX_OUT : pin_sync[4];
    end
  end

  // ***************************************************************
  // read data
  // ***************************************************************
  logic [7:0] line_word;
  logic [7:0] modem_word;
  logic [7:0] rd_d;

  // error flags read as zero as soon as the fifo runs empty, not one cycle later
  assign line_word = {LINE_STATUS_HI, frame_q & fifo_ready, parity_q & fifo_ready, overrun_q,
                      fifo_ready};
  // flags shown before any clear of this read
  assign modem_word = {mi_level[MI_CD], mi_level[MI_RI], mi_level[MI_DSR],
                       mi_level[MI_CTS], delta_q[MI_CD], delta_q[MI_RI],
                       delta_q[MI_DSR], delta_q[MI_CTS]};

  // select the addressed register
  always_comb begin
    rd_d = RST_BYTE;
    if (sel_second_xon_char) begin
      rd_d = second_xon_char_q;
    end else if (sel_first_xoff_char) begin
      rd_d = first_xoff_char_q;
    end else if (sel_line) begin
      rd_d = line_word;
    end else if (sel_modem) begin
      rd_d = modem_word;
    end else if (sel_levels) begin
      rd_d = levels_q;
    end
  end

  // read data held until the next read
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= RST_BYTE;
    end else if (REQ.rd) begin
      RDATA <= rd_d;
    end
  end

endmodule : usf_status_flow
`default_nettype wire

// >>> logic/usf_pkg.sv
// usf_pkg: constants and carrier types for the uart status / flow block
// assumes the host port and the other uart registers live outside the block
package usf_pkg;

  // ***************************************************************
  // register offsets
  // ***************************************************************
  localparam logic [3:0] OFS_LINE_STATUS = 4'h5;
  localparam logic [3:0] OFS_SECOND_XON_CHAR = 4'h5;
  localparam logic [3:0] OFS_MODEM_STATUS = 4'h6;
  localparam logic [3:0] OFS_LEVELS = 4'h6;
  localparam logic [3:0] OFS_FIRST_XOFF_CHAR = 4'h6;

  // ***************************************************************
  // reset values and key values
  // ***************************************************************
  localparam logic [7:0] RST_CHAR = 8'h00;
  localparam logic [7:0] RST_LEVELS = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] LCR_ENHANCED_KEY = 8'hBF;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int LCR_DLAB = 7;
  localparam int MCR_LOOP = 4;
  localparam int MCR_OP2 = 3;
  localparam int MCR_SEL = 2;
  localparam int MCR_RTS = 1;
  localparam int MCR_DTR = 0;
  localparam int SFR_SEL = 2;
  localparam int EFR_ENH = 4;
  localparam int LS_FRAME = 3;
  localparam int LS_PARITY = 2;
  localparam int LS_OVERRUN = 1;
  localparam int LS_READY = 0;
  // modem input vector order: cts, dsr, ri, cd (bits 0..3)
  localparam int MI_CTS = 0;
  localparam int MI_DSR = 1;
  localparam int MI_RI = 2;
  localparam int MI_CD = 3;
  localparam int LV_HALT_LO = 0;
  localparam int LV_RESUME_LO = 4;
  localparam int LV_FIELD_W = 4;
  localparam int LV_SCALE_SH = 2; // threshold is field times four

  // ***************************************************************
  // carrier types
  // ***************************************************************
  typedef struct packed {
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] special_feature;
    logic [7:0] enhanced_feature;
  } usf_ctl_t;

  typedef struct packed {
    logic frame_err;
    logic parity_err;
  } usf_head_t;

  typedef struct packed {
    logic [3:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } usf_req_t;

endpackage : usf_pkg

// >>> logic/usf_sync2.sv
// usf_sync2: two flip-flop synchroniser, one stage pair per bit
// assumes inputs come from pins outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module usf_sync2 #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [WIDTH-1:0] D,
  output logic [WIDTH-1:0] Q
);

  // ***************************************************************
  // per-bit stages
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_q;
      logic sync_q;
      // first stage feeds only the second
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          meta_q <= INIT[g];
          sync_q <= INIT[g];
        end else begin
          meta_q <= D[g];
          sync_q <= meta_q;
        end
      end
      assign Q[g] = sync_q;
    end
  endgenerate

endmodule : usf_sync2
`default_nettype wire

// >>> tb/usf_status_flow_assertions.sv
// usf_status_flow_assertions: port-level timing checks for usf_status_flow
// assumes one clock, async RST and POR, host strobes one cycle long
`timescale 1ns/1ps
`default_nettype none
module usf_status_flow_assertions #(
  parameter int LEVEL_W = 7
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic POR,
  input wire usf_pkg::usf_ctl_t CTL,
  input wire usf_pkg::usf_req_t REQ,
  input wire logic [7:0] RDATA,
  input wire logic MODEM_IRQ_EN,
  input wire logic MODEM_IRQ,
  input wire logic [3:0] LINE_STATUS_HI,
  input wire logic RX_ARRIVE,
  input wire usf_pkg::usf_head_t RX_ARRIVE_INFO,
  input wire logic RX_FULL,
  input wire logic RX_PUSH,
  input wire usf_pkg::usf_head_t RX_PUSH_INFO,
  input wire logic [LEVEL_W-1:0] RX_LEVEL,
  input wire logic AUTO_RTS_EN,
  input wire logic AUTO_SW_EN,
  input wire logic RTS_N,
  input wire logic SEND_XOFF,
  input wire logic SEND_XON,
  input wire logic [7:0] FIRST_XOFF_CHAR_CHAR,
  input wire logic [7:0] SECOND_XON_CHAR_CHAR,
  input wire logic CD_N,
  input wire logic RI_N,
  input wire logic DSR_N,
  input wire logic CTS_N
);
  import usf_pkg::*;
  // ********
  // decode mirror and helper state
  // ********
  logic key_sel, ls_sel, ms_sel, lv_sel, halt_hit, resume_hit, quiet;
  logic [7:0] lv_q;
  logic [11:0] now_v;
  logic [35:0] hist_q;
  logic [2:0] age_q;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // register select as the host port decodes it
  assign key_sel = CTL.line_control == LCR_ENHANCED_KEY && !CTL.special_feature[SFR_SEL];
  assign ls_sel = !key_sel && !CTL.line_control[LCR_DLAB];
  assign ms_sel = ls_sel && !CTL.modem_control[MCR_SEL] && !CTL.special_feature[SFR_SEL];
  assign lv_sel = !key_sel && !ms_sel && CTL.enhanced_feature[EFR_ENH]
    && CTL.modem_control[MCR_SEL] && !CTL.special_feature[SFR_SEL];
  assign halt_hit = RX_LEVEL >= LEVEL_W'({lv_q[3:0], 2'b00});
  assign resume_hit = RX_LEVEL <= LEVEL_W'({lv_q[7:4], 2'b00});
  assign now_v = {CD_N, RI_N, DSR_N, CTS_N, CTL.modem_control};
  assign quiet = age_q == 3'h5 && hist_q == {3{now_v}}; // no change still in the synchroniser
  // shadow of the threshold register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) lv_q <= RST_LEVELS;
    else if (REQ.wr && REQ.addr == OFS_LEVELS && lv_sel) lv_q <= REQ.wdata;
  end
  // cycles since reset and recent modem inputs
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) age_q <= 3'h0;
    else if (age_q != 3'h5) age_q <= age_q + 3'h1;
  end
  always_ff @(posedge CLK) begin
    hist_q <= {hist_q[23:0], now_v};
  end
  rx_push_a: assert property (RX_PUSH == (RX_ARRIVE && !RX_FULL)
    && (!RX_PUSH || RX_PUSH_INFO == RX_ARRIVE_INFO)) else $error("receive push wrong");
  ready_bit_a: assert property (REQ.rd && REQ.addr == OFS_LINE_STATUS && ls_sel |=>
    RDATA[LS_READY] == ($past(RX_LEVEL) != 0) && RDATA[7:4] == $past(LINE_STATUS_HI))
    else $error("line status ready bit wrong");
  rdata_hold_a: assert property (!REQ.rd |=> $stable(RDATA)) else $error("read data moved");
  halt_rts_a: assert property (AUTO_RTS_EN && halt_hit |=> RTS_N)
    else $error("rts not released at halt level");
  resume_rts_a: assert property (AUTO_RTS_EN && resume_hit && !halt_hit |=> !RTS_N)
    else $error("rts not asserted at resume level");
  xoff_cause_a: assert property (SEND_XOFF |-> $past(AUTO_SW_EN) && $past(halt_hit)
    ##1 !SEND_XOFF) else $error("xoff request without cause");
  xon_cause_a: assert property (SEND_XON |-> $past(AUTO_SW_EN) && $past(resume_hit)
    ##1 !SEND_XON) else $error("xon request without cause");
  irq_enable_a: assert property (!MODEM_IRQ_EN |=> !MODEM_IRQ)
    else $error("modem interrupt while disabled");
  msr_clear_a: assert property (REQ.rd && REQ.addr == OFS_MODEM_STATUS && ms_sel && quiet
    |=> !MODEM_IRQ) else $error("modem read left interrupt");
  char_write_a: assert property (disable iff (POR) REQ.wr && key_sel && REQ.addr == OFS_FIRST_XOFF_CHAR
    |=> FIRST_XOFF_CHAR_CHAR == $past(REQ.wdata)) else $error("stop character not stored");
  char_keep_a: assert property (disable iff (POR) !(REQ.wr && key_sel)
    |=> $stable({SECOND_XON_CHAR_CHAR, FIRST_XOFF_CHAR_CHAR})) else $error("flow character changed");
  cover property (SEND_XOFF);
  cover property (SEND_XON);
  cover property (MODEM_IRQ);
  cover property (RX_ARRIVE && RX_FULL);
endmodule : usf_status_flow_assertions
`default_nettype wire

// >>> tb/usf_modem_model.sv
// usf_modem_model: remote modem driving the four status pins and the data line
// assumes the bench sets wanted levels; pins move on the falling edge after
`timescale 1ns/1ps
`default_nettype none
module usf_modem_model (
  input wire logic CLK,
  input wire logic [3:0] WANT_N,
  input wire logic LINE,
  output logic CD_N,
  output logic RI_N,
  output logic DSR_N,
  output logic CTS_N,
  output logic RX_PIN
);
  import usf_pkg::*;
  // ********
  // pin drivers
  // ********
  logic [4:0] want_q = 5'h1F;
  initial {CD_N, RI_N, DSR_N, CTS_N, RX_PIN} = 5'h1F; // idle high
  // take the command on the rising edge, drive it half a cycle later
  always @(posedge CLK) begin
    want_q <= {WANT_N[MI_CD], WANT_N[MI_RI], WANT_N[MI_DSR], WANT_N[MI_CTS], LINE};
  end
  always @(negedge CLK) begin
    {CD_N, RI_N, DSR_N, CTS_N, RX_PIN} <= want_q;
  end
endmodule : usf_modem_model
`default_nettype wire

// >>> tb/testbench.sv
// testbench: register, line status, modem and flow scenarios for usf_status_flow
// assumes the bench plays host, receive fifo and transmitter; a model plays the modem
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import usf_pkg::*;
  localparam int LEVEL_W = 7;
  // ********
  // stimulus and observed signals
  // ********
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic POR = 1'b1;
  usf_ctl_t ctl = '0;
  usf_req_t req = '0;
  usf_head_t arrive_info = '0;
  usf_head_t head_info = '0;
  usf_head_t push_info;
  logic [7:0] rdata, first_xoff_char, second_xon_char;
  logic irq, push, rts_n, xoff, xon, rx_core, cd_n, ri_n, dsr_n, cts_n, rx_pin;
  logic irq_en = 1'b0, arrive = 1'b0, full = 1'b0, head_load = 1'b0;
  logic auto_rts = 1'b0, auto_sw = 1'b0, tx_out = 1'b1, line_bit = 1'b1;
  logic [3:0] ls_hi = 4'h6;
  logic [3:0] want_n = 4'hF;
  logic [LEVEL_W-1:0] level = '0;
  int num_errors = 0;
  int n_tests = 0;
  // 100 MHz clock
  always #5 CLK = ~CLK;
  usf_status_flow #(.LEVEL_W(LEVEL_W)) usf_status_flow_inst (
    .CLK(CLK), .RST(RST), .POR(POR), .CTL(ctl), .REQ(req), .RDATA(rdata),
    .MODEM_IRQ_EN(irq_en), .MODEM_IRQ(irq), .LINE_STATUS_HI(ls_hi), .RX_ARRIVE(arrive),
    .RX_ARRIVE_INFO(arrive_info), .RX_FULL(full), .RX_PUSH(push), .RX_PUSH_INFO(push_info),
    .RX_HEAD_LOAD(head_load), .RX_HEAD_INFO(head_info), .RX_LEVEL(level),
    .AUTO_RTS_EN(auto_rts), .AUTO_SW_EN(auto_sw), .RTS_N(rts_n), .SEND_XOFF(xoff),
    .SEND_XON(xon), .FIRST_XOFF_CHAR_CHAR(first_xoff_char), .SECOND_XON_CHAR_CHAR(second_xon_char), .CD_N(cd_n), .RI_N(ri_n),
    .DSR_N(dsr_n), .CTS_N(cts_n), .RX_PIN(rx_pin), .TX_OUT(tx_out), .RX_CORE(rx_core));
  usf_modem_model usf_modem_model_inst (
    .CLK(CLK), .WANT_N(want_n), .LINE(line_bit), .CD_N(cd_n), .RI_N(ri_n),
    .DSR_N(dsr_n), .CTS_N(cts_n), .RX_PIN(rx_pin));
  // comparison and verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  task automatic idle(input int n);
    repeat (n) @(negedge CLK);
  endtask : idle
  // host accesses: strobe across one rising edge, then one idle cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    idle(1);
    req = '0;
    idle(1);
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    idle(1);
    req = '0;
    check(rdata, e);
    idle(1);
  endtask : rd_chk
  task automatic modem(input logic [3:0] w, input logic [7:0] e);
    want_n = w;
    idle(5);
    rd_chk(OFS_MODEM_STATUS, e);
  endtask : modem
  task automatic head(input usf_head_t i, input logic [7:0] e);
    level = 7'd1;
    head_load = 1'b1;
    head_info = i;
    idle(1);
    head_load = 1'b0;
    rd_chk(OFS_LINE_STATUS, e);
  endtask : head
  task automatic flow(input logic [LEVEL_W-1:0] l, input logic r, input logic [1:0] p);
    level = l;
    idle(1);
    check(8'({rts_n, xon, xoff}), 8'({r, p}));
    idle(1);
    check(8'({rts_n, xon, xoff}), 8'({r, 2'b00}));
  endtask : flow
  task automatic wait_irq;
    for (int i = 0; i < 20; i++) begin
      if (irq === 1'b1) return;
      idle(1);
    end
    num_errors++;
    $display("Error at %0t: interrupt missing", $time);
    print_verdict();
  endtask : wait_irq
  // ********
  // main sequence
  // ********
  initial begin
    idle(4);
    RST = 1'b0;
    POR = 1'b0;
    // flow characters behind the enhanced key
    ctl = '{8'hBF, 8'h00, 8'h00, 8'h00};
    wr(OFS_SECOND_XON_CHAR, 8'hA5);
    wr(OFS_FIRST_XOFF_CHAR, 8'h3C);
    rd_chk(OFS_SECOND_XON_CHAR, 8'hA5);
    check(first_xoff_char, 8'h3C);
    check(second_xon_char, 8'hA5);
    ctl.special_feature = 8'h04;
    wr(OFS_SECOND_XON_CHAR, 8'hFF);
    rd_chk(OFS_SECOND_XON_CHAR, 8'h00);
    ctl.special_feature = 8'h00;
    rd_chk(OFS_SECOND_XON_CHAR, 8'hA5);
    // plain reset keeps the characters, power-on reset clears them
    RST = 1'b1;
    idle(2);
    RST = 1'b0;
    rd_chk(OFS_FIRST_XOFF_CHAR, 8'h3C);
    POR = 1'b1;
    idle(2);
    POR = 1'b0;
    rd_chk(OFS_SECOND_XON_CHAR, RST_CHAR);
    check(first_xoff_char, RST_CHAR);
    // modem inputs, change flags and interrupt
    ctl = '0;
    rd_chk(OFS_MODEM_STATUS, 8'h00);
    modem(4'h7, 8'h88);
    rd_chk(OFS_MODEM_STATUS, 8'h80);
    modem(4'h3, 8'hC0);
    modem(4'h7, 8'h84);
    modem(4'h4, 8'hB3);
    rd_chk(OFS_MODEM_STATUS, 8'hB0);
    irq_en = 1'b1;
    want_n = 4'h5;
    idle(1);
    wait_irq();
    check(8'(irq), 8'h01);
    rd_chk(OFS_MODEM_STATUS, 8'hA1);
    check(8'(irq), 8'h00);
    // loopback substitution and internal serial path
    ctl.modem_control = 8'h1A;
    tx_out = 1'b0;
    idle(5);
    rd_chk(OFS_MODEM_STATUS, 8'h93);
    check(8'(rx_core), 8'h00);
    tx_out = 1'b1;
    idle(1);
    check(8'(rx_core), 8'h01);
    ctl.modem_control = 8'h00;
    line_bit = 1'b0;
    idle(5);
    check(8'(rx_core), 8'h00);
    rd_chk(OFS_MODEM_STATUS, 8'hA3);
    // line status of the head character and overrun
    irq_en = 1'b0;
    rd_chk(OFS_LINE_STATUS, 8'h60);
    head(2'b10, 8'h69);
    head(2'b01, 8'h65);
    full = 1'b1;
    arrive = 1'b1;
    #1;
    check(8'(push), 8'h00);
    idle(1);
    arrive = 1'b0;
    rd_chk(OFS_LINE_STATUS, 8'h67);
    rd_chk(OFS_LINE_STATUS, 8'h65);
    full = 1'b0;
    arrive = 1'b1;
    arrive_info = 2'b11;
    #1;
    check(8'({push, push_info}), 8'h07);
    idle(1);
    arrive = 1'b0;
    level = '0;
    rd_chk(OFS_LINE_STATUS, 8'h60);
    // halt and resume thresholds
    ctl = '{8'h00, 8'h04, 8'h00, 8'h00};
    rd_chk(OFS_LEVELS, 8'h00);
    ctl.enhanced_feature = 8'h10;
    wr(OFS_LEVELS, 8'h24);
    rd_chk(OFS_LEVELS, 8'h24);
    auto_rts = 1'b1;
    auto_sw = 1'b1;
    level = 7'd15;
    idle(2);
    check(8'(rts_n), 8'h00);
    flow(7'd16, 1'b1, 2'b01);
    flow(7'd9, 1'b1, 2'b00);
    flow(7'd8, 1'b0, 2'b10);
    print_verdict();
  end
endmodule : testbench
bind usf_status_flow usf_status_flow_assertions #(.LEVEL_W(LEVEL_W)) usf_status_flow_assertions_inst (
  .CLK(CLK), .RST(RST), .POR(POR), .CTL(CTL), .REQ(REQ), .RDATA(RDATA),
  .MODEM_IRQ_EN(MODEM_IRQ_EN), .MODEM_IRQ(MODEM_IRQ), .LINE_STATUS_HI(LINE_STATUS_HI),
  .RX_ARRIVE(RX_ARRIVE), .RX_ARRIVE_INFO(RX_ARRIVE_INFO), .RX_FULL(RX_FULL),
  .RX_PUSH(RX_PUSH), .RX_PUSH_INFO(RX_PUSH_INFO), .RX_LEVEL(RX_LEVEL),
  .AUTO_RTS_EN(AUTO_RTS_EN), .AUTO_SW_EN(AUTO_SW_EN), .RTS_N(RTS_N), .SEND_XOFF(SEND_XOFF),
  .SEND_XON(SEND_XON), .FIRST_XOFF_CHAR_CHAR(FIRST_XOFF_CHAR_CHAR), .SECOND_XON_CHAR_CHAR(SECOND_XON_CHAR_CHAR), .CD_N(CD_N),
  .RI_N(RI_N), .DSR_N(DSR_N), .CTS_N(CTS_N));
`default_nettype wire
